// ### design/sep_pkg.sv
/*
  Types for the serial programming host.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package sep_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_LOW, ST_HIGH, ST_NEXT, ST_WAIT} sep_state_t;
endpackage : sep_pkg

`default_nettype wire

// ### design/sep_prog_host.sv
/*
  Host that writes one data EEPROM byte or the eight ID bytes of a target
  through its two-wire serial programming port, under APB control.
  Assumes the target samples serial data on the falling serial clock edge and
  that pclk is 10 MHz; the serial clock is made here by a divider.
*/
// The address map and the APB slave port are this design's own decisions.
// What this block does
// - Clear both memory selects before EEPROM write
// - Set write enable before EEPROM write
// - Setting go bit requests the write
// - Send 55h then AAh just before go
// - Hold serial clock low for discharge time
// - Enable writes only around the write
// - Load pointer via moves to A9, AA
// - Load byte via move to A8
// - Move 55h then AAh into A7
// - Poll control via table latch until clear
// - One byte per sequence, end with enable cleared
// - ID panel chosen by table pointer
// - Fill whole 8-byte buffer before programming
// - Command 1100 zero at 3C0006h: single panel
// - Command 1111 programs; NOP holds clock high
// - Commands shifted LSB first on data line
`include "sep_regs.svh"
`default_nettype none

module sep_prog_host
  import sep_pkg::*;
#(
  parameter int unsigned PROG_HOLD_CYC = `SEP_P9_CYC
) (
  input wire logic pclk, // 10 MHz system clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, always high
  output logic pslverr, // APB error on unmapped address
  output logic prog_serial_clock_o, // Serial clock to target
  input wire logic prog_serial_data_i, // Serial data from pin
  output logic prog_serial_data_o, // Serial data to pin
  output logic prog_serial_data_oe // High while driving data
);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  sep_state_t state_reg;
  logic [4:0] step_reg;
  logic [4:0] bit_reg;
  logic [23:0] cnt_reg;
  logic waited_reg;
  logic mode_reg;
  logic start_reg;
  logic done_reg;
  logic [15:0] addr_reg;
  logic [7:0] data_reg;
  logic [63:0] id_reg;
  logic [19:0] frame_reg;
  logic [15:0] prev_pay_reg;
  logic [7:0] rd_reg;
  logic [7:0] last_rd_reg;
  logic [15:0] polls_reg;
  logic sd_meta_reg;
  logic sd_sync_reg;
  logic clk_reg;
  logic sdo_reg;
  logic sdoe_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic hit;
  logic wr_acc;
  logic busy;
  logic is_read;
  logic hold_hi;
  logic half_end;
  logic high_end;
  logic poll_again;
  logic need_wait;
  logic last_step;
  logic finish;

  // One frame = 4 command bits then 16 payload bits, sent bit 0 first.
  function automatic logic [19:0] step_word(input logic id, input logic [4:0] i,
                                            input logic [15:0] a, input logic [7:0] d,
                                            input logic [63:0] w);
    logic [19:0] r;
    r = {`SEP_I_NOP, `SEP_CMD_CORE};
    if (!id) begin
      case (i)
        5'd0: r = {`SEP_I_CLR_FSEL, `SEP_CMD_CORE};
        5'd1: r = {`SEP_I_CLR_CSEL, `SEP_CMD_CORE};
        5'd2: r = {`SEP_OP_MOVLW, a[7:0], `SEP_CMD_CORE};
        5'd3: r = {`SEP_OP_MOVWF, `SEP_F_PTR_LO, `SEP_CMD_CORE};
        5'd4: r = {`SEP_OP_MOVLW, a[15:8], `SEP_CMD_CORE};
        5'd5: r = {`SEP_OP_MOVWF, `SEP_F_PTR_HI, `SEP_CMD_CORE};
        5'd6: r = {`SEP_OP_MOVLW, d, `SEP_CMD_CORE};
        5'd7: r = {`SEP_OP_MOVWF, `SEP_F_LATCH, `SEP_CMD_CORE};
        5'd8: r = {`SEP_I_SET_WRITE_ENABLE_BIT, `SEP_CMD_CORE};
        5'd9: r = {`SEP_OP_MOVLW, `SEP_UNLOCK1, `SEP_CMD_CORE};
        5'd10: r = {`SEP_OP_MOVWF, `SEP_F_UNLOCK, `SEP_CMD_CORE};
        5'd11: r = {`SEP_OP_MOVLW, `SEP_UNLOCK2, `SEP_CMD_CORE};
        5'd12: r = {`SEP_OP_MOVWF, `SEP_F_UNLOCK, `SEP_CMD_CORE};
        5'd13: r = {`SEP_I_SET_GO, `SEP_CMD_CORE};
        5'd14: r = {`SEP_I_CTRL_TO_W, `SEP_CMD_CORE};
        5'd15: r = {`SEP_OP_MOVWF, `SEP_F_TAB_LATCH, `SEP_CMD_CORE};
        5'd16: r = {`SEP_I_NOP, `SEP_CMD_SHOUT};
        5'd17: r = {`SEP_I_CLR_WRITE_ENABLE_BIT, `SEP_CMD_CORE};
        default: r = {`SEP_I_NOP, `SEP_CMD_CORE};
      endcase
    end else begin
      case (i)
        5'd0: r = {`SEP_I_SET_FSEL, `SEP_CMD_CORE};
        5'd1: r = {`SEP_I_SET_CSEL, `SEP_CMD_CORE};
        5'd2: r = {`SEP_OP_MOVLW, `SEP_PANEL_TP_U, `SEP_CMD_CORE};
        5'd3: r = {`SEP_OP_MOVWF, `SEP_F_TP_UPPER, `SEP_CMD_CORE};
        5'd4: r = {`SEP_OP_MOVLW, `SEP_ZERO_BYTE, `SEP_CMD_CORE};
        5'd5: r = {`SEP_OP_MOVWF, `SEP_F_TP_HIGH, `SEP_CMD_CORE};
        5'd6: r = {`SEP_OP_MOVLW, `SEP_PANEL_TP_L, `SEP_CMD_CORE};
        5'd7: r = {`SEP_OP_MOVWF, `SEP_F_TP_LOW, `SEP_CMD_CORE};
        5'd8: r = {`SEP_I_NOP, `SEP_CMD_TW};
        5'd9: r = {`SEP_I_SET_FSEL, `SEP_CMD_CORE};
        5'd10: r = {`SEP_I_CLR_CSEL, `SEP_CMD_CORE};
        5'd11: r = {`SEP_OP_MOVLW, `SEP_ID_TP_U, `SEP_CMD_CORE};
        5'd12: r = {`SEP_OP_MOVWF, `SEP_F_TP_UPPER, `SEP_CMD_CORE};
        5'd13: r = {`SEP_OP_MOVLW, `SEP_ZERO_BYTE, `SEP_CMD_CORE};
        5'd14: r = {`SEP_OP_MOVWF, `SEP_F_TP_HIGH, `SEP_CMD_CORE};
        5'd15: r = {`SEP_OP_MOVLW, `SEP_ZERO_BYTE, `SEP_CMD_CORE};
        5'd16: r = {`SEP_OP_MOVWF, `SEP_F_TP_LOW, `SEP_CMD_CORE};
        5'd17: r = {w[15:0], `SEP_CMD_TW_INC2};
        5'd18: r = {w[31:16], `SEP_CMD_TW_INC2};
        5'd19: r = {w[47:32], `SEP_CMD_TW_INC2};
        5'd20: r = {w[63:48], `SEP_CMD_TW_PROG};
        default: r = {`SEP_I_NOP, `SEP_CMD_CORE};
      endcase
    end
    return r;
  endfunction : step_word

  // -----------------------------------------------------------------
  // Sequencer decode
  // -----------------------------------------------------------------
  assign busy = state_reg != ST_IDLE;
  assign is_read = frame_reg[3:0] == `SEP_CMD_SHOUT;
  // The NOP after a program command stretches its last command clock high.
  assign hold_hi = mode_reg && step_reg == `SEP_ID_NOP && bit_reg == `SEP_CMD_BITS - 5'd1;
  assign half_end = cnt_reg == 24'(`SEP_SCLK_HALF_CYC - 1);
  assign high_end = hold_hi ? cnt_reg == 24'(PROG_HOLD_CYC - 1) : half_end;
  assign poll_again = !mode_reg && step_reg == `SEP_EE_READ && rd_reg[`SEP_GO_BIT];
  assign need_wait = mode_reg ? step_reg == `SEP_ID_NOP : step_reg == `SEP_EE_READ;
  assign last_step = step_reg == (mode_reg ? `SEP_ID_NOP : `SEP_EE_LAST);
  assign finish = state_reg == ST_NEXT && !poll_again && !(need_wait && !waited_reg) && last_step;

  // -----------------------------------------------------------------
  // Pin input synchroniser
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_meta_reg <= 1'b0;
      sd_sync_reg <= 1'b0;
    end else begin
      sd_meta_reg <= prog_serial_data_i;
      sd_sync_reg <= sd_meta_reg;
    end
  end

  // -----------------------------------------------------------------
  // Frame sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      step_reg <= 5'h0;
      bit_reg <= 5'h0;
      cnt_reg <= 24'h0;
      waited_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            step_reg <= 5'h0;
            waited_reg <= 1'b0;
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          bit_reg <= 5'h0;
          cnt_reg <= 24'h0;
          state_reg <= ST_LOW;
        end
        ST_LOW: begin
          if (half_end) begin
            cnt_reg <= 24'h0;
            state_reg <= ST_HIGH;
          end else begin
            cnt_reg <= cnt_reg + 24'h1;
          end
        end
        ST_HIGH: begin
          if (high_end) begin
            cnt_reg <= 24'h0;
            if (bit_reg == `SEP_LAST_BIT) begin
              state_reg <= ST_NEXT;
            end else begin
              bit_reg <= bit_reg + 5'h1;
              state_reg <= ST_LOW;
            end
          end else begin
            cnt_reg <= cnt_reg + 24'h1;
          end
        end
        ST_NEXT: begin
          if (poll_again) begin
            step_reg <= `SEP_EE_POLL;
            state_reg <= ST_LOAD;
          end else if (need_wait && !waited_reg) begin
            cnt_reg <= 24'h0;
            state_reg <= ST_WAIT;
          end else if (last_step) begin
            state_reg <= ST_IDLE;
          end else begin
            step_reg <= step_reg + 5'h1;
            waited_reg <= 1'b0;
            state_reg <= ST_LOAD;
          end
        end
        ST_WAIT: begin
          if (cnt_reg == 24'(`SEP_P10_CYC - 1)) begin
            waited_reg <= 1'b1;
            state_reg <= ST_NEXT;
          end else begin
            cnt_reg <= cnt_reg + 24'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Frame contents and read-back
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_reg <= 20'h0;
      prev_pay_reg <= 16'h0;
      rd_reg <= 8'h0;
      last_rd_reg <= 8'h0;
    end else begin
      if (state_reg == ST_LOAD) begin
        frame_reg <= step_word(mode_reg, step_reg, addr_reg, data_reg, id_reg);
        prev_pay_reg <= frame_reg[19:4];
      end
      // Shifted-out byte arrives LSB first on the last eight clocks.
      if (state_reg == ST_HIGH && high_end && is_read && bit_reg >= `SEP_READ_BIT0) begin
        rd_reg <= {sd_sync_reg, rd_reg[7:1]};
      end
      if (state_reg == ST_NEXT && !mode_reg && step_reg == `SEP_EE_READ) begin
        last_rd_reg <= rd_reg;
      end
    end
  end

  // -----------------------------------------------------------------
  // Pin drivers
  // -----------------------------------------------------------------
  // Data moves one cycle after the clock falls, so the target never sees
  // data change on its sampling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sdoe_reg <= 1'b0;
    end else begin
      clk_reg <= state_reg == ST_HIGH;
      if (state_reg == ST_LOW && cnt_reg == 24'h1) begin
        sdo_reg <= frame_reg[bit_reg];
        sdoe_reg <= !(is_read && bit_reg >= `SEP_CMD_BITS);
      end else if (state_reg == ST_IDLE) begin
        sdoe_reg <= 1'b0;
      end
    end
  end

  assign prog_serial_clock_o = clk_reg;
  assign prog_serial_data_o = sdo_reg;
  assign prog_serial_data_oe = sdoe_reg;

  // -----------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      `SEP_OFF_CTRL: rd_mux = {30'h0, mode_reg, 1'b0};
      `SEP_OFF_STAT: rd_mux = {polls_reg, last_rd_reg, 6'h0, done_reg, busy};
      `SEP_OFF_ADDR: rd_mux = {16'h0, addr_reg};
      `SEP_OFF_DATA: rd_mux = {24'h0, data_reg};
      `SEP_OFF_ID_LO: rd_mux = id_reg[31:0];
      `SEP_OFF_ID_HI: rd_mux = id_reg[63:32];
      default: hit = 1'b0;
    endcase
  end

  assign wr_acc = psel && penable && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (psel && !penable) begin
      prdata_reg <= rd_mux;
    end
  end

  // Settings are frozen while a sequence runs: the frame builder reads them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 1'b0;
      start_reg <= 1'b0;
      addr_reg <= 16'h0;
      data_reg <= 8'h0;
      id_reg <= 64'h0;
    end else begin
      start_reg <= wr_acc && !busy && paddr == `SEP_OFF_CTRL && pwdata[`SEP_CTRL_START];
      if (wr_acc && !busy) begin
        case (paddr)
          `SEP_OFF_CTRL: mode_reg <= pwdata[`SEP_CTRL_MODE];
          `SEP_OFF_ADDR: addr_reg <= pwdata[15:0];
          `SEP_OFF_DATA: data_reg <= pwdata[7:0];
          `SEP_OFF_ID_LO: id_reg[31:0] <= pwdata;
          `SEP_OFF_ID_HI: id_reg[63:32] <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // Done is sticky; a finishing sequence wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
      polls_reg <= 16'h0;
    end else begin
      if (finish) begin
        done_reg <= 1'b1;
      end else if (start_reg || (wr_acc && paddr == `SEP_OFF_STAT && pwdata[`SEP_STAT_DONE])) begin
        done_reg <= 1'b0;
      end
      if (start_reg) begin
        polls_reg <= 16'h0;
      end else if (state_reg == ST_NEXT && poll_again) begin
        polls_reg <= polls_reg + 16'h1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  logic write_enable_bit_seen_reg;
  logic [23:0] hi_run_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_enable_bit_seen_reg <= 1'b0;
      hi_run_reg <= 24'h0;
    end else begin
      hi_run_reg <= clk_reg ? hi_run_reg + 24'h1 : 24'h0;
      if (start_reg || (state_reg == ST_LOW && frame_reg[19:4] == `SEP_I_CLR_WRITE_ENABLE_BIT)) begin
        write_enable_bit_seen_reg <= 1'b0;
      end else if (state_reg == ST_LOW && frame_reg[19:4] == `SEP_I_SET_WRITE_ENABLE_BIT) begin
        write_enable_bit_seen_reg <= 1'b1;
      end
    end
  end

  default clocking sep_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  go_needs_write_enable_bit_a: assert property (
    (state_reg == ST_LOW && frame_reg[19:4] == `SEP_I_SET_GO) |-> write_enable_bit_seen_reg)
    else $error("go sent without write enable");
  unlock_before_go_a: assert property (
    (state_reg == ST_LOW && frame_reg[19:4] == `SEP_I_SET_GO) |-> prev_pay_reg == {`SEP_OP_MOVWF, `SEP_F_UNLOCK})
    else $error("go not preceded by unlock write");
  lsb_order_a: assert property (
    (state_reg == ST_HIGH && clk_reg && sdoe_reg) |-> sdo_reg == frame_reg[bit_reg])
    else $error("data bit does not match frame bit");
  read_release_a: assert property (
    (state_reg == ST_HIGH && is_read && bit_reg >= `SEP_CMD_BITS) |-> !sdoe_reg)
    else $error("data driven during shift-out");
  poll_loop_a: assert property (
    (state_reg == ST_NEXT && poll_again) |=> state_reg == ST_LOAD && step_reg == `SEP_EE_POLL ##1 state_reg == ST_LOW)
    else $error("poll did not restart");
  p9_hold_a: assert property (
    (state_reg == ST_HIGH && hold_hi && high_end) |-> hi_run_reg == 24'(PROG_HOLD_CYC - 2))
    else $error("program hold high time wrong");
  p10_low_a: assert property (
    (state_reg == ST_WAIT) |-> !clk_reg && !prog_serial_clock_o)
    else $error("clock not low in discharge wait");
  wait_len_a: assert property (
    $fell(state_reg == ST_WAIT) |-> $past(cnt_reg) == 24'(`SEP_P10_CYC - 1))
    else $error("discharge wait length wrong");
  write_enable_bit_off_a: assert property (
    (finish && !mode_reg) |-> frame_reg[19:4] == `SEP_I_CLR_WRITE_ENABLE_BIT)
    else $error("write sequence ended with writes enabled");
  panel_mode_a: assert property (
    (state_reg == ST_LOW && frame_reg[3:0] == `SEP_CMD_TW) |->
      frame_reg[19:4] == 16'h0 && prev_pay_reg == {`SEP_OP_MOVWF, `SEP_F_TP_LOW})
    else $error("panel mode write malformed");

endmodule : sep_prog_host

`default_nettype wire

// ### design/sep_regs.svh
/*
  Offsets, field positions, command codes, sequence step indices and timing
  counts for the serial programming host.
  Assumes a 10 MHz pclk and a target that accepts 4-bit commands and 16-bit
  payloads shifted LSB first.
*/
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH

// -----------------------------------------------------------------
// APB register offsets and fields
// -----------------------------------------------------------------
`define SEP_OFF_CTRL 12'h000
`define SEP_OFF_STAT 12'h004
`define SEP_OFF_ADDR 12'h008
`define SEP_OFF_DATA 12'h00c
`define SEP_OFF_ID_LO 12'h010
`define SEP_OFF_ID_HI 12'h014
`define SEP_CTRL_START 0
`define SEP_CTRL_MODE 1
`define SEP_STAT_BUSY 0
`define SEP_STAT_DONE 1

// -----------------------------------------------------------------
// Serial commands and core instruction pieces
// -----------------------------------------------------------------
`define SEP_CMD_CORE 4'h0
`define SEP_CMD_SHOUT 4'h2
`define SEP_CMD_TW 4'hc
`define SEP_CMD_TW_INC2 4'hd
`define SEP_CMD_TW_PROG 4'hf
`define SEP_OP_MOVLW 8'h0e
`define SEP_OP_MOVWF 8'h6e
`define SEP_F_UNLOCK 8'ha7
`define SEP_F_LATCH 8'ha8
`define SEP_F_PTR_LO 8'ha9
`define SEP_F_PTR_HI 8'haa
`define SEP_F_TAB_LATCH 8'hf5
`define SEP_F_TP_LOW 8'hf6
`define SEP_F_TP_HIGH 8'hf7
`define SEP_F_TP_UPPER 8'hf8
`define SEP_I_CLR_FSEL 16'h9ea6
`define SEP_I_SET_FSEL 16'h8ea6
`define SEP_I_CLR_CSEL 16'h9ca6
`define SEP_I_SET_CSEL 16'h8ca6
`define SEP_I_SET_WRITE_ENABLE_BIT 16'h84a6
`define SEP_I_CLR_WRITE_ENABLE_BIT 16'h94a6
`define SEP_I_SET_GO 16'h82a6
`define SEP_I_CTRL_TO_W 16'h50a6
`define SEP_I_NOP 16'h0000
`define SEP_UNLOCK1 8'h55
`define SEP_UNLOCK2 8'haa
`define SEP_PANEL_TP_U 8'h3c
`define SEP_PANEL_TP_L 8'h06
`define SEP_ID_TP_U 8'h20
`define SEP_ZERO_BYTE 8'h00
`define SEP_GO_BIT 1

// -----------------------------------------------------------------
// Sequence steps and frame bits
// -----------------------------------------------------------------
`define SEP_EE_POLL 5'd14
`define SEP_EE_READ 5'd16
`define SEP_EE_LAST 5'd17
`define SEP_ID_NOP 5'd21
`define SEP_CMD_BITS 5'd4
`define SEP_READ_BIT0 5'd12
`define SEP_LAST_BIT 5'd19

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SEP_PCLK_MHZ 10
`define SEP_SCLK_HALF_NS 400
`define SEP_SCLK_HALF_CYC ((`SEP_SCLK_HALF_NS * `SEP_PCLK_MHZ) / 1000)
`define SEP_P9_NS 1000000
`define SEP_P9_CYC ((`SEP_P9_NS * `SEP_PCLK_MHZ + 999) / 1000)
`define SEP_P10_NS 100000
`define SEP_P10_CYC ((`SEP_P10_NS * `SEP_PCLK_MHZ + 999) / 1000)

`endif

// ### verif/sep_target_model.sv
/*
  Behavioural model of the programmed device: serial shifter, core moves,
  write control, unlock, byte store and ID panel buffer.
  Assumes the host makes the serial clock and releases data during read bits.
*/
`default_nettype none

module sep_target_model #(
  parameter int BUSY_FALLS = 50
) (
  input wire logic sclk, // Serial clock from host
  input wire logic rst_n, // Reset, active low
  input wire logic din, // Resolved data wire
  output logic dout, // Data driven back
  output logic doe // High while driving
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [19:0] sr;
  logic [4:0] cnt;
  logic [3:0] cmd;
  logic [7:0] w, ctrl, ptr_lo, ptr_hi, latch, tab;
  logic [1:0] stage;
  logic [21:0] tp;
  logic [7:0] bufb [8];
  logic single;
  logic [63:0] id;
  logic [7:0] ee [logic [15:0]];
  int falls;
  task automatic store(input logic [7:0] a);
    case (a)
      8'ha7: stage = (w == 8'h55) ? 2'd1 : (stage == 2'd1 && w == 8'haa) ? 2'd2 : 2'd0;
      8'ha8: latch = w;
      8'ha9: ptr_lo = w;
      8'haa: ptr_hi = w;
      8'hf5: tab = w;
      8'hf6: tp[7:0] = w;
      8'hf7: tp[15:8] = w;
      8'hf8: tp[21:16] = w[5:0];
      default: ;
    endcase
  endtask : store
  task automatic exec(input logic [3:0] c, input logic [15:0] p);
    if (c == 4'h0 && p[15:8] == 8'h0e) w = p[7:0];
    else if (c == 4'h0 && p[15:8] == 8'h6e) store(p[7:0]);
    else if (c == 4'h0 && p == 16'h50a6) w = ctrl;
    else if (c == 4'h0 && p[7:0] == 8'ha6 && p[15:12] == 4'h9) ctrl[p[11:9]] = 1'b0;
    else if (c == 4'h0 && p[7:0] == 8'ha6 && p[15:9] == 7'h41) begin
      // Go only lands after a fresh unlock with writes enabled at data memory
      if (ctrl[2] && ctrl[7:6] == 2'b00 && stage == 2'd2) begin
        ctrl[1] = 1'b1;
        falls = 0;
      end
      stage = 2'd0;
    end else if (c == 4'h0 && p[7:0] == 8'ha6 && p[15:12] == 4'h8) ctrl[p[11:9]] = 1'b1;
    else if (c == 4'hc && tp == 22'h3c0006 && p == 16'h0000) single = 1'b1;
    else if (c == 4'hd || c == 4'hf) begin
      bufb[tp[2:0]] = p[7:0];
      bufb[tp[2:0] + 3'd1] = p[15:8];
      if (c == 4'hf && single && tp[21:16] == 6'h20)
        id = {bufb[7], bufb[6], bufb[5], bufb[4], bufb[3], bufb[2], bufb[1], bufb[0]};
      tp = tp + 22'd2;
    end
  endtask : exec
  // Data sampled on each falling edge, LSB first
  always @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt = 5'd0; ctrl = 8'h00; stage = 2'd0; falls = -1; single = 1'b0; id = 64'h0; doe = 1'b0; tp = 22'h0;
    end else begin
      sr = {din, sr[19:1]};
      cnt = cnt + 5'd1;
      if (cnt == 5'd4) cmd = sr[19:16];
      if (falls >= 0) falls++;
      if (falls == 4) ee[{ptr_hi, ptr_lo}] = latch;
      if (falls == BUSY_FALLS) begin
        ctrl[1] = 1'b0;
        falls = -1;
      end
      if (cnt == 5'd20) begin
        cnt = 5'd0;
        doe = 1'b0;
        exec(sr[3:0], sr[19:4]);
      end
    end
  end
  always @(posedge sclk) begin
    doe = (cmd == 4'h2 && cnt >= 5'd12);
    dout = tab[cnt - 5'd12];
  end
endmodule : sep_target_model

`default_nettype wire

// ### verif/tb.sv
/*
  Self-checking bench: APB master, serial wire resolution, device model.
  Assumes the host answers APB with no wait states and a 10 MHz pclk.
*/
`include "sep_regs.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected %s expected %h seen %h", n, e, a); end end
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sclk, hd, hoe, dd, doe, last = 1'b0;
  wire sdata = hoe ? hd : doe ? dd : ~last;
  int error_cnt = 0, checks_done = 0;
  logic [15:0] a;
  logic [7:0] d;
  logic [63:0] idv;
  always #50 pclk = ~pclk;
  always @(posedge pclk) last <= sdata;
  sep_prog_host #(.PROG_HOLD_CYC(20)) u_sep_prog_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_serial_clock_o(sclk), .prog_serial_data_i(sdata), .prog_serial_data_o(hd),
    .prog_serial_data_oe(hoe));
  sep_target_model u_sep_target_model (.sclk(sclk), .rst_n(presetn), .din(sdata), .dout(dd), .doe(doe));
  task conclude;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      conclude();
    end
  endtask : apb
  // Poll the done flag; the bound covers the longest sequence
  task wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, `SEP_OFF_STAT, 32'h0);
      n++;
    end while (rd[`SEP_STAT_DONE] !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      error_cnt++;
      conclude();
    end
  endtask : wait_done
  function automatic logic [7:0] exp_poll();
    return 8'h04; // Writes still enabled, go clear, data memory selected
  endfunction : exp_poll
  initial begin
    void'($urandom(32'h0fa0));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SEP_OFF_STAT, 32'h0);
    `CHK("status reset", 32'h0, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'hffff : 16'($urandom());
      d = (i == 0) ? 8'h00 : 8'($urandom());
      apb(1'b1, `SEP_OFF_ADDR, {16'h0, a});
      apb(1'b1, `SEP_OFF_DATA, {24'h0, d});
      apb(1'b1, `SEP_OFF_CTRL, 32'h1);
      repeat (4) @(posedge pclk);
      apb(1'b1, `SEP_OFF_DATA, {24'h0, ~d});
      wait_done();
      `CHK("poll byte", exp_poll(), rd[15:8])
      `CHK("stored byte", d, u_sep_target_model.ee[a])
      `CHK("go cleared", 1'b0, u_sep_target_model.ctrl[1])
      `CHK("write_enable_bit cleared", 1'b0, u_sep_target_model.ctrl[2])
      apb(1'b1, `SEP_OFF_STAT, 32'h2);
    end
    idv = {$urandom(), $urandom()};
    apb(1'b1, `SEP_OFF_ID_LO, idv[31:0]);
    apb(1'b1, `SEP_OFF_ID_HI, idv[63:32]);
    apb(1'b1, `SEP_OFF_CTRL, 32'h3);
    wait_done();
    `CHK("single panel", 1'b1, u_sep_target_model.single)
    `CHK("id bytes", idv, u_sep_target_model.id)
    conclude();
  end
endmodule : tb

`default_nettype wire
